// ### verilog/usi_params.svh
`ifndef USI_PARAMS_SVH
`define USI_PARAMS_SVH

// cpu register indices on the io port
`define REG_SHIFT_DATA     2'h0
`define REG_FLAGS_COUNTER  2'h1
`define REG_CONTROL        2'h2

// reset values
`define RST_SHIFT_DATA     8'h00
`define RST_CONTROL        8'h00
`define RST_COUNT          4'h0

// flags_counter_reg fields
`define FLD_START_FLAG     7
`define FLD_OVF_FLAG       6
`define FLD_STOP_FLAG      5
`define FLD_COLLISION      4
`define FLD_COUNT_HI       3
`define FLD_COUNT_LO       0

// control_reg fields
`define FLD_START_IE       7
`define FLD_OVF_IE         6
`define FLD_WIRE_HI        5
`define FLD_WIRE_LO        4
`define FLD_CSRC_HI        3
`define FLD_CSRC_LO        2
`define FLD_STROBE_EN      1
`define FLD_TOGGLE         0

// counter maximum and acknowledge preload
`define COUNT_MAX          4'hF
`define COUNT_ACK_PRELOAD  4'hE

// data line delay ahead of the start detector
`define SYS_CLK_PERIOD_NS  10
`define SDA_DELAY_MIN_NS   50
`define SDA_DELAY_MAX_NS   300
`define SDA_DELAY_CYC \
	((`SDA_DELAY_MIN_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// ### verilog/usi_pkg.sv
package usi_pkg;

	typedef enum logic [1:0] {
		WIRE_OFF   = 2'b00,
		WIRE_THREE = 2'b01,
		WIRE_TWO   = 2'b10,
		WIRE_TWO_H = 2'b11
	} wire_mode_t;

	typedef enum logic [1:0] {
		CSRC_SOFT  = 2'b00,
		CSRC_TIMER = 2'b01,
		CSRC_EXT_P = 2'b10,
		CSRC_EXT_N = 2'b11
	} clk_src_t;

endpackage

// ### verilog/usi_start_wake.sv
`timescale 1ns/1ps
// clockless start catcher: with two_wire_en set, a falling data line while the clock line is
// high arms the wake request, which stays until the flag clear pulse
module usi_start_wake (
	input  wire logic sda_in,
	input  wire logic scl_in,
	input  wire logic two_wire_en,
	input  wire logic clr_n,
	output logic      wake_ff
);

	always_ff @(negedge sda_in or negedge clr_n) begin
		if (!clr_n) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= wake_ff | (scl_in & two_wire_en);
		end
	end

endmodule

// ### verilog/usi_two_wire_shift_unit.sv
`timescale 1ns/1ps
`include "usi_params.svh"

module usi_two_wire_shift_unit
	import usi_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic [1:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata_ff,
	input  wire logic       global_irq_en,
	input  wire logic       timer0_ovf,
	input  wire logic       scl_in,
	output logic            scl_out_ff,
	output logic            scl_oe_ff,
	input  wire logic       sda_in,
	output logic            sda_out_ff,
	output logic            sda_oe_ff,
	output logic            do_out_ff,
	output logic            do_oe_ff,
	input  wire logic       scl_port_bit,
	input  wire logic       scl_dir_out,
	input  wire logic       sda_port_bit,
	input  wire logic       sda_dir_out,
	output logic            port_toggle_ff,
	output logic            start_irq_ff,
	output logic            ovf_irq_ff,
	output logic            wake_ff
);

	localparam int DLY = `SDA_DELAY_CYC;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection

	logic           scl_s1_ff;
	logic           scl_s2_ff;
	logic           scl_d_ff;
	logic           sda_s1_ff;
	logic           sda_s2_ff;
	logic [DLY-1:0] sda_dly_ff;
	logic           sda_dly_d_ff;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_s1_ff    <= 1'b1;
			scl_s2_ff    <= 1'b1;
			scl_d_ff     <= 1'b1;
			sda_s1_ff    <= 1'b1;
			sda_s2_ff    <= 1'b1;
			sda_dly_ff   <= '1;
			sda_dly_d_ff <= 1'b1;
		end else begin
			scl_s1_ff    <= scl_in;
			scl_s2_ff    <= scl_s1_ff;
			scl_d_ff     <= scl_s2_ff;
			sda_s1_ff    <= sda_in;
			sda_s2_ff    <= sda_s1_ff;
			sda_dly_ff   <= {sda_dly_ff[DLY-2:0], sda_s2_ff};
			sda_dly_d_ff <= sda_dly_ff[DLY-1];
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic sda_dly_fall;
	logic sda_dly_rise;

	assign scl_rise     = scl_s2_ff & ~scl_d_ff;
	assign scl_fall     = ~scl_s2_ff & scl_d_ff;
	assign sda_dly_fall = ~sda_dly_ff[DLY-1] & sda_dly_d_ff;
	assign sda_dly_rise = sda_dly_ff[DLY-1] & ~sda_dly_d_ff;

	////////////////////////////////////////////////////////////////////////
	// core state

	logic [7:0] data_ff;
	logic [3:0] cnt_ff;
	logic       start_flag_ff;
	logic       ovf_flag_ff;
	logic       stop_flag_ff;
	logic       start_ie_ff;
	logic       ovf_ie_ff;
	wire_mode_t wm_ff;
	clk_src_t   cs_ff;
	logic       strobe_mode_ff;
	logic       start_hold_ff;
	logic       ovf_hold_ff;
	logic       latch_ff;
	logic       wake_clr_n_ff;

	logic [7:0] nxt_data;
	logic [3:0] nxt_cnt;
	logic       nxt_start_flag;
	logic       nxt_ovf_flag;
	logic       nxt_stop_flag;
	logic       nxt_start_ie;
	logic       nxt_ovf_ie;
	wire_mode_t nxt_wm;
	clk_src_t   nxt_cs;
	logic       nxt_strobe_mode;
	logic       nxt_start_hold;
	logic       nxt_ovf_hold;
	logic       nxt_latch;
	logic       nxt_wake_clr_n;
	logic [7:0] nxt_rdata;
	logic       nxt_scl_oe;
	logic       nxt_sda_oe;
	logic       nxt_do_out;
	logic       nxt_do_oe;
	logic       nxt_toggle;
	logic       nxt_start_irq;
	logic       nxt_ovf_irq;

	logic wr_data;
	logic wr_stat;
	logic wr_ctrl;
	logic sw_clk;
	logic tg_clk;
	logic cnt_tick;
	logic shift_tick;
	logic overflow;
	logic two_wire;
	logic start_ev;
	logic latch_open;
	logic collision;

	always_comb begin
		wr_data = 1'b0;
		wr_stat = 1'b0;
		wr_ctrl = 1'b0;
		if (io_wr && io_addr == `REG_SHIFT_DATA) begin
			wr_data = 1'b1;
		end else if (io_wr && io_addr == `REG_FLAGS_COUNTER) begin
			wr_stat = 1'b1;
		end else if (io_wr && io_addr == `REG_CONTROL) begin
			wr_ctrl = 1'b1;
		end

		two_wire = wm_ff[1];
		sw_clk   = wr_ctrl & io_wdata[`FLD_STROBE_EN];
		tg_clk   = wr_ctrl & io_wdata[`FLD_TOGGLE];

		cnt_tick = 1'b0;
		shift_tick = 1'b0;
		case (cs_ff)
			CSRC_SOFT: begin
				cnt_tick   = sw_clk;
				shift_tick = sw_clk;
			end
			CSRC_TIMER: begin
				cnt_tick   = timer0_ovf;
				shift_tick = timer0_ovf;
			end
			CSRC_EXT_P: begin
				cnt_tick   = strobe_mode_ff ? tg_clk : (scl_rise | scl_fall);
				shift_tick = scl_rise;
			end
			default: begin
				cnt_tick   = strobe_mode_ff ? tg_clk : (scl_rise | scl_fall);
				shift_tick = scl_fall;
			end
		endcase

		overflow = cnt_tick & (cnt_ff == `COUNT_MAX) & ~wr_stat;

		nxt_data = data_ff;
		if (wr_data) begin
			nxt_data = io_wdata;
		end else if (shift_tick) begin
			nxt_data = {data_ff[6:0], sda_s2_ff};
		end

		nxt_cnt = cnt_ff;
		if (wr_stat) begin
			nxt_cnt = io_wdata[`FLD_COUNT_HI:`FLD_COUNT_LO];
		end else if (cnt_tick) begin
			nxt_cnt = cnt_ff + 4'h1;
		end

		start_ev = (two_wire & sda_dly_fall & scl_s2_ff)
			| (~two_wire & cs_ff[1] & ~strobe_mode_ff
			& (scl_rise | scl_fall));

		nxt_start_flag = start_ev | (start_flag_ff
			& ~(wr_stat & io_wdata[`FLD_START_FLAG]));
		nxt_ovf_flag = overflow | (ovf_flag_ff
			& ~(wr_stat & io_wdata[`FLD_OVF_FLAG]));
		nxt_stop_flag = (two_wire & sda_dly_rise & scl_s2_ff)
			| (stop_flag_ff & ~(wr_stat & io_wdata[`FLD_STOP_FLAG]));

		nxt_start_ie    = start_ie_ff;
		nxt_ovf_ie      = ovf_ie_ff;
		nxt_wm          = wm_ff;
		nxt_cs          = cs_ff;
		nxt_strobe_mode = strobe_mode_ff;
		if (wr_ctrl) begin
			nxt_start_ie = io_wdata[`FLD_START_IE];
			nxt_ovf_ie   = io_wdata[`FLD_OVF_IE];
			nxt_wm       = wire_mode_t'(io_wdata[`FLD_WIRE_HI:`FLD_WIRE_LO]);
			nxt_cs       = clk_src_t'(io_wdata[`FLD_CSRC_HI:`FLD_CSRC_LO]);
			nxt_strobe_mode = io_wdata[`FLD_CSRC_HI]
				& io_wdata[`FLD_STROBE_EN];
		end

		nxt_start_hold = nxt_start_flag & two_wire
			& (start_hold_ff | scl_fall);
		nxt_ovf_hold = nxt_ovf_flag & (wm_ff == WIRE_TWO_H)
			& (ovf_hold_ff | scl_fall);

		latch_open = ~cs_ff[1] | (scl_s2_ff == cs_ff[0]);
		nxt_latch  = latch_open ? nxt_data[7] : latch_ff;

		nxt_sda_oe = two_wire & sda_dir_out & (~latch_ff | ~sda_port_bit);
		nxt_scl_oe = (two_wire & scl_dir_out & ~scl_port_bit)
			| nxt_start_hold | nxt_ovf_hold;
		nxt_do_out = latch_ff;
		nxt_do_oe  = (wm_ff == WIRE_THREE) & sda_dir_out;
		nxt_toggle = tg_clk;

		collision = two_wire & (data_ff[7] != sda_s2_ff);

		nxt_rdata = 8'h00;
		if (io_addr == `REG_SHIFT_DATA) begin
			nxt_rdata = data_ff;
		end else if (io_addr == `REG_FLAGS_COUNTER) begin
			nxt_rdata = {start_flag_ff, ovf_flag_ff, stop_flag_ff,
				collision, cnt_ff};
		end else if (io_addr == `REG_CONTROL) begin
			nxt_rdata = {start_ie_ff, ovf_ie_ff, wm_ff, cs_ff, 2'b00};
		end

		nxt_start_irq = nxt_start_flag & nxt_start_ie & global_irq_en;
		nxt_ovf_irq   = nxt_ovf_flag & nxt_ovf_ie & global_irq_en;

		nxt_wake_clr_n = ~(wr_stat & io_wdata[`FLD_START_FLAG]);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			data_ff        <= `RST_SHIFT_DATA;
			cnt_ff         <= `RST_COUNT;
			start_flag_ff  <= 1'b0;
			ovf_flag_ff    <= 1'b0;
			stop_flag_ff   <= 1'b0;
			start_ie_ff    <= 1'b0;
			ovf_ie_ff      <= 1'b0;
			wm_ff          <= WIRE_OFF;
			cs_ff          <= CSRC_SOFT;
			strobe_mode_ff <= 1'b0;
			start_hold_ff  <= 1'b0;
			ovf_hold_ff    <= 1'b0;
			latch_ff       <= 1'b0;
			wake_clr_n_ff  <= 1'b1;
			io_rdata_ff    <= 8'h00;
			scl_out_ff     <= 1'b0;
			scl_oe_ff      <= 1'b0;
			sda_out_ff     <= 1'b0;
			sda_oe_ff      <= 1'b0;
			do_out_ff      <= 1'b0;
			do_oe_ff       <= 1'b0;
			port_toggle_ff <= 1'b0;
			start_irq_ff   <= 1'b0;
			ovf_irq_ff     <= 1'b0;
		end else begin
			data_ff        <= nxt_data;
			cnt_ff         <= nxt_cnt;
			start_flag_ff  <= nxt_start_flag;
			ovf_flag_ff    <= nxt_ovf_flag;
			stop_flag_ff   <= nxt_stop_flag;
			start_ie_ff    <= nxt_start_ie;
			ovf_ie_ff      <= nxt_ovf_ie;
			wm_ff          <= nxt_wm;
			cs_ff          <= nxt_cs;
			strobe_mode_ff <= nxt_strobe_mode;
			start_hold_ff  <= nxt_start_hold;
			ovf_hold_ff    <= nxt_ovf_hold;
			latch_ff       <= nxt_latch;
			wake_clr_n_ff  <= nxt_wake_clr_n;
			io_rdata_ff    <= nxt_rdata;
			scl_out_ff     <= 1'b0;
			scl_oe_ff      <= nxt_scl_oe;
			sda_out_ff     <= 1'b0;
			sda_oe_ff      <= nxt_sda_oe;
			do_out_ff      <= nxt_do_out;
			do_oe_ff       <= nxt_do_oe;
			port_toggle_ff <= nxt_toggle;
			start_irq_ff   <= nxt_start_irq;
			ovf_irq_ff     <= nxt_ovf_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clockless wake path

	logic wake_clr_n;

	assign wake_clr_n = rstn & wake_clr_n_ff;

	usi_start_wake u_start_wake (
		.sda_in      (sda_in),
		.scl_in      (scl_in),
		.two_wire_en (wm_ff[1]),
		.clr_n       (wake_clr_n),
		.wake_ff     (wake_ff)
	);

endmodule

// ### tb/usi_properties.sv
`timescale 1ns/1ps
module usi_properties (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic [1:0] io_addr,
	input wire logic       io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata_ff,
	input wire logic       global_irq_en,
	input wire logic       sda_dir_out,
	input wire logic       scl_out_ff,
	input wire logic       sda_out_ff,
	input wire logic       do_oe_ff,
	input wire logic       port_toggle_ff,
	input wire logic       start_irq_ff,
	input wire logic       ovf_irq_ff
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_clr_start;
		io_wr && io_addr == 2'h1 && io_wdata[7];
	endsequence
	sequence s_clr_ovf;
		io_wr && io_addr == 2'h1 && io_wdata[6];
	endsequence
	sequence s_toggle;
		io_wr && io_addr == 2'h2 && io_wdata[0];
	endsequence
	property p_open_drain;
		!scl_out_ff && !sda_out_ff;
	endproperty
	property p_clr_start;
		s_clr_start |=> ##1 !start_irq_ff;
	endproperty
	property p_clr_ovf;
		s_clr_ovf |=> ##1 !ovf_irq_ff;
	endproperty
	property p_start_irq;
		start_irq_ff |-> $past(global_irq_en);
	endproperty
	property p_ovf_irq;
		ovf_irq_ff |-> $past(global_irq_en);
	endproperty
	property p_toggle;
		s_toggle |=> port_toggle_ff;
	endproperty
	property p_unmapped;
		io_addr == 2'h3 |=> io_rdata_ff == 8'h00;
	endproperty
	property p_do_oe;
		do_oe_ff |-> $past(sda_dir_out);
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("line driven high");
	a_clr_start: assert property (p_clr_start)
		else $error("start irq kept after clear");
	a_clr_ovf: assert property (p_clr_ovf)
		else $error("ovf irq kept after clear");
	a_start_irq: assert property (p_start_irq)
		else $error("start irq without global enable");
	a_ovf_irq: assert property (p_ovf_irq)
		else $error("ovf irq without global enable");
	a_toggle: assert property (p_toggle)
		else $error("no toggle pulse");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_do_oe: assert property (p_do_oe)
		else $error("data out enabled without direction");
endmodule

bind usi_two_wire_shift_unit usi_properties u_chk (
	.sys_clk(sys_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
	.io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff),
	.global_irq_en(global_irq_en), .sda_dir_out(sda_dir_out),
	.scl_out_ff(scl_out_ff), .sda_out_ff(sda_out_ff),
	.do_oe_ff(do_oe_ff), .port_toggle_ff(port_toggle_ff),
	.start_irq_ff(start_irq_ff), .ovf_irq_ff(ovf_irq_ff));

// ### tb/usi_bus_master.sv
`timescale 1ns/1ps
module usi_bus_master (
	input  wire logic scl_line,
	input  wire logic sda_line,
	output logic      scl_drv,
	output logic      sda_drv
);
	// released lines float high through the pull-ups
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic rise();
		scl_drv = 1'b1;
		wait (scl_line);
		#40;
	endtask
	task automatic put_bit(input logic b, output logic got);
		// data moves late in the low phase so the delayed copy in the
		// start detector changes only after the next clock fall
		#30 sda_drv = b;
		#10;
		rise();
		got = sda_line;
		scl_drv = 1'b0;
	endtask
	task automatic send(input logic [7:0] v);
		logic g;
		for (int i = 7; i >= 0; i--) put_bit(v[i], g);
	endtask
	task automatic start();
		#3 sda_drv = 1'b0;
		#120 scl_drv = 1'b0;
		#40;
	endtask
	task automatic stop();
		// low data outlasts the detector delay before the clock rises
		sda_drv = 1'b0;
		#80;
		rise();
		sda_drv = 1'b1;
		// let the delayed rise reach the stop flag
		#120;
	endtask
	task automatic pulse();
		scl_drv = 1'b0;
		#40 scl_drv = 1'b1;
		#40;
	endtask
endmodule

// ### tb/usi_two_wire_shift_unit_tb.sv
`timescale 1ns/1ps
module usi_two_wire_shift_unit_tb;
	typedef struct {string nm; logic [7:0] e;} note_t;
	logic       sys_clk, rstn, io_wr, gie, t0, sda_dir, rd_v, rd_d;
	logic       scl_oe, sda_oe, s_irq, o_irq, wake, do_out, ack;
	logic [1:0] io_addr;
	logic [7:0] io_wdata, rdata, d;
	wire        scl_in, sda_in, m_scl, m_sda;
	int         err_count, n_compared, cyc;
	note_t      q[$];
	assign scl_in = m_scl & ~scl_oe;
	assign sda_in = m_sda & ~sda_oe;
	usi_bus_master M (.scl_line(scl_in), .sda_line(sda_in),
		.scl_drv(m_scl), .sda_drv(m_sda));
	usi_two_wire_shift_unit DUT (
		.sys_clk(sys_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
		.io_wdata(io_wdata), .io_rdata_ff(rdata), .global_irq_en(gie),
		.timer0_ovf(t0), .scl_in(scl_in), .scl_out_ff(),
		.scl_oe_ff(scl_oe), .sda_in(sda_in), .sda_out_ff(),
		.sda_oe_ff(sda_oe), .do_out_ff(do_out), .do_oe_ff(),
		.scl_port_bit(1'b0), .scl_dir_out(1'b0), .sda_port_bit(1'b1),
		.sda_dir_out(sda_dir), .port_toggle_ff(),
		.start_irq_ff(s_irq), .ovf_irq_ff(o_irq), .wake_ff(wake));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(logic [1:0] a, logic [7:0] v);
		@(negedge sys_clk);
		io_addr = a;
		io_wdata = v;
		io_wr = 1'b1;
		@(negedge sys_clk);
		io_wr = 1'b0;
	endtask
	// driver notes the expected value, monitor below compares it
	task automatic rd(string nm, logic [1:0] a, logic [7:0] e);
		@(negedge sys_clk);
		io_addr = a;
		rd_v = 1'b1;
		q.push_back('{nm, e});
		@(negedge sys_clk);
		rd_v = 1'b0;
	endtask
	always @(posedge sys_clk) rd_d <= rd_v;
	always @(negedge sys_clk) begin
		note_t n;
		if (rd_d) begin
			n = q.pop_front();
			chk(n.nm, n.e, rdata);
		end
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		{rstn, io_wr, t0, sda_dir, rd_v, rd_d} = '0;
		gie = 1'b1;
		io_addr = 2'h0;
		io_wdata = 8'h00;
		err_count = 0;
		n_compared = 0;
		cyc = 0;
		void'($urandom(10));
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk) rstn = 1'b1;
		for (int a = 0; a < 4; a++) rd("reset", a[1:0], 8'h00);
		wr(2'h3, 8'hFF);
		rd("unmapped", 2'h3, 8'h00);
		d = $urandom;
		wr(2'h0, d);
		rd("data", 2'h0, d);
		wr(2'h2, 8'h03);
		rd("shift", 2'h0, {d[6:0], 1'b1});
		rd("count", 2'h1, 8'h01);
		wr(2'h2, 8'h04);
		wr(2'h1, 8'h0F);
		@(negedge sys_clk) t0 = 1'b1;
		@(negedge sys_clk) t0 = 1'b0;
		rd("timer ovf", 2'h1, 8'h40);
		wr(2'h1, 8'h40);
		rd("ovf clear", 2'h1, 8'h00);
		sda_dir = 1'b1;
		wr(2'h2, 8'h10);
		wr(2'h0, 8'h80);
		repeat (3) @(negedge sys_clk);
		chk("data out", 8'h01, {7'h0, do_out});
		sda_dir = 1'b0;
		wr(2'h2, 8'h08);
		M.pulse();
		rd("edge start", 2'h1, 8'h82);
		wr(2'h1, 8'hC0);
		wr(2'h2, 8'hF8);
		M.start();
		repeat (4) @(negedge sys_clk);
		chk("hold", 8'h01, {7'h0, scl_oe});
		chk("start irq", 8'h01, {7'h0, s_irq});
		chk("wake", 8'h01, {7'h0, wake});
		gie = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("irq gate", 8'h00, {7'h0, s_irq});
		gie = 1'b1;
		rd("start flags", 2'h1, 8'h81);
		wr(2'h1, 8'hC0);
		repeat (3) @(negedge sys_clk);
		chk("wake clr", 8'h00, {7'h0, wake});
		d = $urandom;
		M.send(d);
		repeat (4) @(negedge sys_clk);
		chk("ovf hold", 8'h01, {7'h0, scl_oe});
		chk("ovf irq", 8'h01, {7'h0, o_irq});
		rd("rx byte", 2'h0, d);
		rd("rx flags", 2'h1, 8'h40 | {3'h0, d[7] ^ d[0], 4'h0});
		sda_dir = 1'b1;
		wr(2'h0, 8'h00);
		wr(2'h1, 8'h4E);
		M.put_bit(1'b1, ack);
		chk("ack", 8'h00, {7'h0, ack});
		repeat (4) @(negedge sys_clk);
		chk("ack hold", 8'h01, {7'h0, scl_oe});
		sda_dir = 1'b0;
		wr(2'h1, 8'h40);
		M.stop();
		rd("stop", 2'h1, 8'h31);
		end_sim();
	end
endmodule
